// ===== design/tsp_pkg.sv
/*
 package for the single-speed trolley positioner: register map, field
 positions, reset values, codes. assumes nothing beyond a SystemVerilog tool.
*/
`default_nettype none
package tsp_pkg;
   // =========================================================
   // register byte offsets
   localparam logic [7:0] TSP_CTRL_OFF = 8'h00;
   localparam logic [7:0] TSP_CFG_OFF = 8'h04;
   localparam logic [7:0] TSP_SPEED_OFF = 8'h08;
   localparam logic [7:0] TSP_STAT_OFF = 8'h0C;
   // =========================================================
   // control register fields
   localparam int TSP_CTRL_RUN_BIT = 0;
   localparam int TSP_CTRL_INV_BIT = 1;
   localparam int TSP_CTRL_BYP_BIT = 2;
   // =========================================================
   // config register fields
   localparam int TSP_CFG_APP_LSB = 0;
   localparam int TSP_CFG_APP_W = 8;
   localparam int TSP_CFG_EPS_BIT = 8;
   localparam int TSP_CFG_TRIG_LSB = 12;
   localparam int TSP_CFG_TRIG_W = 3;
   // =========================================================
   // codes and reset values
   localparam logic [7:0] TSP_APP_TROLLEY_ONE = 8'h0B;
   localparam logic [2:0] TSP_TRIG_LVL_HIGH = 3'h1;
   localparam logic [2:0] TSP_TRIG_LVL_LOW = 3'h2;
   localparam logic [2:0] TSP_TRIG_EDGE_RISE = 3'h3;
   localparam logic [2:0] TSP_TRIG_EDGE_FALL = 3'h4;
   localparam logic [31:0] TSP_CTRL_RST = 32'h0000_0000;
   localparam logic [31:0] TSP_CFG_RST = 32'h0000_110B;
   localparam logic [15:0] TSP_SPEED_RST = 16'h0000;
   localparam logic [1:0] TSP_RESP_OKAY = 2'h0;
   localparam logic [1:0] TSP_RESP_SLVERR = 2'h2;
   // =========================================================
   // sensor index
   localparam int TSP_SENS_POS = 0;
   localparam int TSP_SENS_NEG = 1;
   localparam int TSP_SENS_CTR = 2;
   localparam int TSP_NSENS = 3;
   typedef enum logic [2:0]
   {
      TSP_IDLE = 3'b001,
      TSP_RUN = 3'b010,
      TSP_HOLD = 3'b100
   } tsp_state_t;
endpackage : tsp_pkg
`default_nettype wire

// ===== design/tsp_sensor_in.sv
/*
 sensor input conditioning: two-flop synchroniser and trigger-type detect
 per sensor. assumes raw pins asynchronous to aclk.
*/
`timescale 1ns/10ps
`default_nettype none
module tsp_sensor_in
#(
   parameter int N = 3
)
(
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic [N-1:0] pin,
   input wire logic [2:0] trig_type,
   output logic [N-1:0] level_act,
   output logic [N-1:0] edge_hit
);
   import tsp_pkg::*;
   logic [N-1:0] meta_reg;
   logic [N-1:0] sync_reg;
   logic [N-1:0] prev_reg;
   if (N < 1)
   begin : g_bad_n
      $error("tsp_sensor_in: N must be at least 1");
   end
   // =========================================================
   // per-sensor chain
   genvar g;
   generate
      for (g = 0; g < N; g++)
      begin : g_sens
         always_ff @(posedge aclk)
         begin
            if (!aresetn)
            begin
               meta_reg[g] <= 1'b0;
               sync_reg[g] <= 1'b0;
               prev_reg[g] <= 1'b0;
            end
            else
            begin
               meta_reg[g] <= pin[g];
               sync_reg[g] <= meta_reg[g];
               prev_reg[g] <= sync_reg[g];
            end
         end
         // TSP_TRIG_LVL_LOW setting means the sensor fires on a low input
         assign level_act[g] = (trig_type == TSP_TRIG_LVL_LOW) ?
                               !sync_reg[g] : sync_reg[g];
         assign edge_hit[g] = (trig_type == TSP_TRIG_EDGE_FALL) ?
                              (prev_reg[g] & !sync_reg[g]) :
                              (!prev_reg[g] & sync_reg[g]);
      end
   endgenerate
endmodule : tsp_sensor_in
`default_nettype wire

// ===== design/tsp_positioner.sv
/*
 single-speed trolley positioner with AXI4-Lite register slave.
 assumes one 40 MHz clock, sensors on raw pins, a drive that takes a
 signed speed setpoint and a run enable.
*/
`timescale 1ns/10ps
`default_nettype none
module tsp_positioner
#(
   parameter int SPEED_W = 16
)
(
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic [7:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [7:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic [tsp_pkg::TSP_NSENS-1:0] sensor_pin,
   output logic motor_run,
   output logic signed [SPEED_W-1:0] speed_setpoint
);
   import tsp_pkg::*;
   if (SPEED_W < 2 || SPEED_W > 16)
   begin : g_bad_speed_w
      $error("tsp_positioner: SPEED_W must be 2..16");
   end
   // =========================================================
   // registers
   logic [31:0] ctrl_reg;
   logic [31:0] cfg_reg;
   logic [15:0] speed_reg;
   logic aw_got_reg, w_got_reg, bvalid_reg, rvalid_reg;
   logic [7:0] awaddr_reg;
   logic [31:0] wdata_reg;
   logic [3:0] wstrb_reg;
   logic [1:0] bresp_reg, rresp_reg;
   logic [31:0] rdata_reg;
   tsp_state_t state_reg, state_next;
   logic dir_neg_reg;
   logic pos_lock_reg, pos_lock_next;
   logic neg_lock_reg, neg_lock_next;
   logic run_prev_reg;
   logic ctr_stop_reg;
   logic [1:0] last_cause_reg, last_cause_next;
   logic run_out_reg;
   logic signed [SPEED_W-1:0] speed_out_reg;
   // =========================================================
   // sensors
   logic [TSP_NSENS-1:0] lvl, edg;
   wire [2:0] trig = cfg_reg[TSP_CFG_TRIG_LSB +: TSP_CFG_TRIG_W];
   tsp_sensor_in #(.N(TSP_NSENS)) u_sens
   (
      .aclk(aclk),
      .aresetn(aresetn),
      .pin(sensor_pin),
      .trig_type(trig),
      .level_act(lvl),
      .edge_hit(edg)
   );
   wire trig_level = (trig == TSP_TRIG_LVL_HIGH) ||
                     (trig == TSP_TRIG_LVL_LOW);
   wire [TSP_NSENS-1:0] hit = trig_level ? lvl : edg;
   // =========================================================
   // decode
   wire app_on = cfg_reg[TSP_CFG_APP_LSB +: TSP_CFG_APP_W] ==
                 TSP_APP_TROLLEY_ONE;
   wire eps_on = cfg_reg[TSP_CFG_EPS_BIT];
   wire run_cmd = ctrl_reg[TSP_CTRL_RUN_BIT] && app_on;
   wire run_rise = run_cmd && !run_prev_reg;
   wire req_neg = ctrl_reg[TSP_CTRL_INV_BIT];
   wire bypass = ctrl_reg[TSP_CTRL_BYP_BIT];
   wire ctr_hit = hit[TSP_SENS_CTR] && !bypass;
   // ends are interlocks only with shutdown enabled (set at reset, software may clear it)
   wire pos_stop = eps_on && !dir_neg_reg && hit[TSP_SENS_POS];
   wire neg_stop = eps_on && dir_neg_reg && hit[TSP_SENS_NEG];
   wire ctr_stop = eps_on && ctr_hit;
   wire start_ok = req_neg ? !neg_lock_reg : !pos_lock_reg;
   // =========================================================
   // sequencer
   always_comb
   begin
      state_next = state_reg;
      pos_lock_next = pos_lock_reg;
      neg_lock_next = neg_lock_reg;
      last_cause_next = last_cause_reg;
      unique case (state_reg)
         TSP_IDLE:
         begin
            if (run_rise && start_ok)
            begin
               state_next = TSP_RUN;
               pos_lock_next = 1'b0;
               neg_lock_next = 1'b0;
            end
         end
         TSP_RUN:
         begin
            if (!run_cmd)
               state_next = TSP_IDLE;
            else if (pos_stop)
            begin
               state_next = TSP_IDLE;
               pos_lock_next = 1'b1;
               last_cause_next = 2'h1;
            end
            else if (neg_stop)
            begin
               state_next = TSP_IDLE;
               neg_lock_next = 1'b1;
               last_cause_next = 2'h2;
            end
            else if (ctr_stop)
            begin
               last_cause_next = 2'h3;
               // level center stop pauses; edge center stop needs new run
               state_next = trig_level ? TSP_HOLD : TSP_IDLE;
            end
         end
         TSP_HOLD:
         begin
            if (!run_cmd)
               state_next = TSP_IDLE;
            else if (!ctr_stop)
               state_next = TSP_RUN;
         end
         default:
            state_next = TSP_IDLE;
      endcase
   end
   wire moving = state_reg == TSP_RUN;
   wire dir_next = (state_reg == TSP_IDLE) ? req_neg : dir_neg_reg;
   // top bit dropped: a large magnitude must not flip the direction
   wire signed [SPEED_W-1:0] mag = {1'b0, speed_reg[SPEED_W-2:0]};
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         state_reg <= TSP_IDLE;
         dir_neg_reg <= 1'b0;
         pos_lock_reg <= 1'b0;
         neg_lock_reg <= 1'b0;
         run_prev_reg <= 1'b0;
         last_cause_reg <= 2'h0;
         run_out_reg <= 1'b0;
         speed_out_reg <= '0;
      end
      else
      begin
         state_reg <= state_next;
         dir_neg_reg <= dir_next;
         pos_lock_reg <= pos_lock_next;
         neg_lock_reg <= neg_lock_next;
         run_prev_reg <= run_cmd;
         last_cause_reg <= last_cause_next;
         run_out_reg <= (state_next == TSP_RUN);
         speed_out_reg <= (state_next != TSP_RUN) ? '0 :
                          (dir_next ? -mag : mag);
      end
   end
   assign motor_run = run_out_reg;
   assign speed_setpoint = speed_out_reg;
   // =========================================================
   // axi4-lite slave, one write and one read at a time
   wire aw_take = s_axi_awvalid && s_axi_awready;
   wire w_take = s_axi_wvalid && s_axi_wready;
   wire do_write = aw_got_reg && w_got_reg && !bvalid_reg;
   wire ar_take = s_axi_arvalid && s_axi_arready;
   wire wr_ctrl = awaddr_reg == TSP_CTRL_OFF;
   wire wr_cfg = awaddr_reg == TSP_CFG_OFF;
   wire wr_speed = awaddr_reg == TSP_SPEED_OFF;
   wire wr_stat = awaddr_reg == TSP_STAT_OFF;
   wire wr_ok = wr_ctrl || wr_cfg || wr_speed || wr_stat;
   wire [31:0] bmask = {{8{wstrb_reg[3]}}, {8{wstrb_reg[2]}},
                        {8{wstrb_reg[1]}}, {8{wstrb_reg[0]}}};
   wire [31:0] stat_word = {24'h0, ctr_stop_reg, last_cause_reg,
                            neg_lock_reg, pos_lock_reg, dir_neg_reg,
                            moving, app_on};
   wire [31:0] rd_word = (s_axi_araddr == TSP_CTRL_OFF) ? ctrl_reg :
                         (s_axi_araddr == TSP_CFG_OFF) ? cfg_reg :
                         (s_axi_araddr == TSP_SPEED_OFF) ?
                            {16'h0, speed_reg} :
                         (s_axi_araddr == TSP_STAT_OFF) ? stat_word :
                         32'h0000_0000;
   wire rd_ok = (s_axi_araddr == TSP_CTRL_OFF) ||
                (s_axi_araddr == TSP_CFG_OFF) ||
                (s_axi_araddr == TSP_SPEED_OFF) ||
                (s_axi_araddr == TSP_STAT_OFF);
   assign s_axi_awready = !aw_got_reg && !bvalid_reg;
   assign s_axi_wready = !w_got_reg && !bvalid_reg;
   assign s_axi_arready = !rvalid_reg;
   assign s_axi_bvalid = bvalid_reg;
   assign s_axi_bresp = bresp_reg;
   assign s_axi_rvalid = rvalid_reg;
   assign s_axi_rdata = rdata_reg;
   assign s_axi_rresp = rresp_reg;
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         aw_got_reg <= 1'b0;
         w_got_reg <= 1'b0;
         bvalid_reg <= 1'b0;
         awaddr_reg <= 8'h00;
         wdata_reg <= 32'h0000_0000;
         wstrb_reg <= 4'h0;
         bresp_reg <= TSP_RESP_OKAY;
      end
      else
      begin
         if (aw_take)
         begin
            aw_got_reg <= 1'b1;
            awaddr_reg <= s_axi_awaddr;
         end
         if (w_take)
         begin
            w_got_reg <= 1'b1;
            wdata_reg <= s_axi_wdata;
            wstrb_reg <= s_axi_wstrb;
         end
         if (do_write)
         begin
            aw_got_reg <= 1'b0;
            w_got_reg <= 1'b0;
            bvalid_reg <= 1'b1;
            bresp_reg <= wr_ok ? TSP_RESP_OKAY : TSP_RESP_SLVERR;
         end
         else if (bvalid_reg && s_axi_bready)
            bvalid_reg <= 1'b0;
      end
   end
   // status register is read-only; writes to it are accepted and dropped
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         ctrl_reg <= TSP_CTRL_RST;
         cfg_reg <= TSP_CFG_RST;
         speed_reg <= TSP_SPEED_RST;
      end
      else if (do_write)
      begin
         if (wr_ctrl)
            ctrl_reg <= (ctrl_reg & ~bmask) | (wdata_reg & bmask & 32'h7);
         if (wr_cfg)
            cfg_reg <= (cfg_reg & ~bmask) | (wdata_reg & bmask &
                                             32'h0000_71FF);
         if (wr_speed)
            speed_reg <= (speed_reg & ~bmask[15:0]) |
                         (wdata_reg[15:0] & bmask[15:0]);
      end
   end
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         rvalid_reg <= 1'b0;
         rdata_reg <= 32'h0000_0000;
         rresp_reg <= TSP_RESP_OKAY;
         ctr_stop_reg <= 1'b0;
      end
      else
      begin
         ctr_stop_reg <= ctr_stop;
         if (ar_take)
         begin
            rvalid_reg <= 1'b1;
            rdata_reg <= rd_word;
            rresp_reg <= rd_ok ? TSP_RESP_OKAY : TSP_RESP_SLVERR;
         end
         else if (rvalid_reg && s_axi_rready)
            rvalid_reg <= 1'b0;
      end
   end
endmodule : tsp_positioner
`default_nettype wire

// ===== tb/tsp_positioner_assertions.sv
/*
 port checks for the trolley positioner, bound into every instance.
 assumes the bus master offers write address and data in one cycle.
*/
`timescale 1ns/10ps
`default_nettype none
module tsp_positioner_assertions
#(
   parameter int SPEED_W = 16
)
(
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic [7:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   input wire logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic s_axi_wvalid,
   input wire logic s_axi_wready,
   input wire logic s_axi_bvalid,
   input wire logic s_axi_arvalid,
   input wire logic s_axi_arready,
   input wire logic [1:0] s_axi_rresp,
   input wire logic s_axi_rvalid,
   input wire logic [tsp_pkg::TSP_NSENS-1:0] sensor_pin,
   input wire logic motor_run,
   input wire logic signed [SPEED_W-1:0] speed_setpoint
);
   import tsp_pkg::*;
   // ==========
   // config shadow
   logic [31:0] cfg_q;
   logic cfg_wr;
   logic lvl;
   logic neg;
   assign cfg_wr = s_axi_awvalid && s_axi_awready && s_axi_wvalid
      && s_axi_wready && s_axi_awaddr == TSP_CFG_OFF;
   assign lvl = cfg_q[TSP_CFG_EPS_BIT] && cfg_q[14:12] == TSP_TRIG_LVL_HIGH;
   assign neg = speed_setpoint[SPEED_W-1];
   // shadow may lead a cycle: only trusted while config is quiet
   always_ff @(posedge aclk)
      if (!aresetn)
         cfg_q <= TSP_CFG_RST;
      else if (cfg_wr)
         cfg_q <= s_axi_wdata;
   // ==========
   // checks
   default clocking cb @(posedge aclk);
   endclocking
   default disable iff (!aresetn);
   chk_idle_zero: assert property (
      !motor_run |-> speed_setpoint == '0)
      else $error("speed not zero while stopped");
   chk_dir_keep: assert property (motor_run && $past(motor_run)
      && speed_setpoint != '0 && $past(speed_setpoint) != '0
      |-> neg == $past(neg))
      else $error("direction changed while moving");
   chk_app_start: assert property ($rose(motor_run)
      |-> cfg_q[7:0] == TSP_APP_TROLLEY_ONE)
      else $error("start with wrong application");
   chk_pos_stop: assert property (lvl && motor_run && !neg
      && sensor_pin[TSP_SENS_POS] |-> ##[1:4] !motor_run)
      else $error("positive end did not stop");
   chk_neg_stop: assert property (lvl && motor_run && neg
      && sensor_pin[TSP_SENS_NEG] |-> ##[1:4] !motor_run)
      else $error("negative end did not stop");
   chk_wr_answer: assert property (s_axi_awvalid && s_axi_awready
      && s_axi_wvalid && s_axi_wready |-> ##[1:2] s_axi_bvalid)
      else $error("write response missing");
   chk_rd_answer: assert property (s_axi_arvalid && s_axi_arready
      |=> s_axi_rvalid)
      else $error("read response missing");
   chk_w_block: assert property (s_axi_bvalid
      |-> !s_axi_awready && !s_axi_wready)
      else $error("write taken with response pending");
   chk_ar_block: assert property (s_axi_rvalid |-> !s_axi_arready)
      else $error("read taken with data pending");
   cover property ($fell(motor_run));
   cover property ($rose(motor_run) && neg);
   cover property (s_axi_rvalid && s_axi_rresp == TSP_RESP_SLVERR);
endmodule : tsp_positioner_assertions
bind tsp_positioner tsp_positioner_assertions
   #(.SPEED_W(SPEED_W)) u_chk
(
   .aclk(aclk),
   .aresetn(aresetn),
   .s_axi_awaddr(s_axi_awaddr),
   .s_axi_awvalid(s_axi_awvalid),
   .s_axi_awready(s_axi_awready),
   .s_axi_wdata(s_axi_wdata),
   .s_axi_wvalid(s_axi_wvalid),
   .s_axi_wready(s_axi_wready),
   .s_axi_bvalid(s_axi_bvalid),
   .s_axi_arvalid(s_axi_arvalid),
   .s_axi_arready(s_axi_arready),
   .s_axi_rresp(s_axi_rresp),
   .s_axi_rvalid(s_axi_rvalid),
   .sensor_pin(sensor_pin),
   .motor_run(motor_run),
   .speed_setpoint(speed_setpoint)
);
`default_nettype wire

// ===== tb/tsp_sensor_model.sv
/*
 three raw position contacts for the positioner, set by the bench.
 assumes changes land only right after a clock edge.
*/
`timescale 1ns/10ps
`default_nettype none
module tsp_sensor_model
(
   input wire logic aclk,
   input wire logic [2:0] want,
   output logic [2:0] sensor_pin
);
   // ==========
   // contacts
   // push-pull contacts: no released state to model
   always @(posedge aclk)
      sensor_pin <= want;
endmodule : tsp_sensor_model
`default_nettype wire

// ===== tb/tb_tsp_positioner.sv
/*
 bench for the trolley positioner: bus master tasks, sensor model and
 a queue monitor. assumes the checker binds itself.
*/
`timescale 1ns/10ps
`default_nettype none
module tb_tsp_positioner;
   import tsp_pkg::*;
   logic aclk = 1'b0;
   logic aresetn = 1'b0;
   logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
   logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
   logic [3:0] s_axi_wstrb = 4'hF;
   logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
   logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
   logic s_axi_awready, s_axi_wready, s_axi_bvalid;
   logic s_axi_arready, s_axi_rvalid, motor_run;
   logic [1:0] s_axi_bresp, s_axi_rresp;
   logic [2:0] sensor_pin, want = 3'h0;
   logic signed [15:0] speed_setpoint;
   logic [15:0] spd;
   logic [33:0] rq[$];
   logic [1:0] bq[$];
   int n_errors = 0, checks = 0, cyc = 0, seed = 56, tn = 0;
   tsp_positioner u_dut
   (
      .aclk(aclk),
      .aresetn(aresetn),
      .s_axi_awaddr(s_axi_awaddr),
      .s_axi_awvalid(s_axi_awvalid),
      .s_axi_awready(s_axi_awready),
      .s_axi_wdata(s_axi_wdata),
      .s_axi_wstrb(s_axi_wstrb),
      .s_axi_wvalid(s_axi_wvalid),
      .s_axi_wready(s_axi_wready),
      .s_axi_bresp(s_axi_bresp),
      .s_axi_bvalid(s_axi_bvalid),
      .s_axi_bready(s_axi_bready),
      .s_axi_araddr(s_axi_araddr),
      .s_axi_arvalid(s_axi_arvalid),
      .s_axi_arready(s_axi_arready),
      .s_axi_rdata(s_axi_rdata),
      .s_axi_rresp(s_axi_rresp),
      .s_axi_rvalid(s_axi_rvalid),
      .s_axi_rready(s_axi_rready),
      .sensor_pin(sensor_pin),
      .motor_run(motor_run),
      .speed_setpoint(speed_setpoint)
   );
   tsp_sensor_model u_sens
   (
      .aclk(aclk),
      .want(want),
      .sensor_pin(sensor_pin)
   );
   initial forever #12.5 aclk = ~aclk;
   // ==========
   // compare and report
   task automatic miss(input logic [31:0] e, input logic [31:0] g);
      n_errors++;
      $display("unexpected t=%0t exp=%h got=%h", $time, e, g);
   endtask : miss
   task automatic cmp_d(input logic [31:0] e, input logic [31:0] g);
      checks++;
      if (g !== e) miss(e, g);
   endtask : cmp_d
   task automatic cmp_r(input logic [1:0] e, input logic [1:0] g);
      checks++;
      if (g !== e) miss({30'h0, e}, {30'h0, g});
   endtask : cmp_r
   task automatic cmp_m(input logic [16:0] e, input logic [16:0] g);
      checks++;
      if (g !== e) miss({15'h0, e}, {15'h0, g});
   endtask : cmp_m
   task automatic print_verdict;
      $display("checks=%0d n_errors=%0d", checks, n_errors);
      if (n_errors == 0 && checks > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask : print_verdict
   task automatic endt;
      tn++;
      $display("test %0d done", tn);
   endtask : endt
   // ==========
   // bus master
   task automatic wr(input logic [7:0] a, input logic [31:0] d,
      input logic [1:0] r);
      logic pa, pw;
      pa = 1'b1;
      pw = 1'b1;
      bq.push_back(r);
      @(posedge aclk);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      while (pa || pw)
      begin
         @(posedge aclk);
         pa = pa && !s_axi_awready;
         pw = pw && !s_axi_wready;
         s_axi_awvalid <= pa;
         s_axi_wvalid <= pw;
      end
      while (s_axi_bvalid !== 1'b1) @(posedge aclk);
      s_axi_bready <= 1'b0;
   endtask : wr
   task automatic rd(input logic [7:0] a, input logic [31:0] d,
      input logic [1:0] r);
      rq.push_back({r, d});
      @(posedge aclk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      do @(posedge aclk); while (s_axi_arready !== 1'b1);
      s_axi_arvalid <= 1'b0;
      do @(posedge aclk); while (s_axi_rvalid !== 1'b1);
      s_axi_rready <= 1'b0;
   endtask : rd
   // fixed settle covers start latency and the 3-edge stop path
   task automatic mot(input logic r, input logic [15:0] s);
      repeat (6) @(posedge aclk);
      cmp_m({r, s}, {motor_run, speed_setpoint});
   endtask : mot
   // ==========
   // monitor and watchdog
   always @(posedge aclk)
   begin
      if (s_axi_bvalid && s_axi_bready) cmp_r(bq.pop_front(), s_axi_bresp);
      if (s_axi_rvalid && s_axi_rready)
      begin
         cmp_d(rq[0][31:0], s_axi_rdata);
         cmp_r(rq[0][33:32], s_axi_rresp);
         void'(rq.pop_front());
      end
      cyc++;
      if (cyc == 4000)
      begin
         n_errors++;
         print_verdict();
      end
   end
   // ==========
   // scenarios
   initial
   begin
      spd = 16'($random(seed)) & 16'h3FFF | 16'h0001;
      repeat (3) @(posedge aclk);
      aresetn <= 1'b1;
      rd(TSP_CTRL_OFF, TSP_CTRL_RST, TSP_RESP_OKAY);
      rd(TSP_CFG_OFF, TSP_CFG_RST, TSP_RESP_OKAY);
      rd(TSP_SPEED_OFF, 32'h0, TSP_RESP_OKAY);
      rd(8'h10, 32'h0, TSP_RESP_SLVERR);
      wr(8'h10, 32'hFFFF_FFFF, TSP_RESP_SLVERR);
      wr(TSP_SPEED_OFF, {16'h0, spd}, TSP_RESP_OKAY);
      rd(TSP_SPEED_OFF, {16'h0, spd}, TSP_RESP_OKAY);
      endt();
      wr(TSP_CTRL_OFF, 32'h1, TSP_RESP_OKAY);
      mot(1'b1, spd);
      want <= 3'h1;
      mot(1'b0, 16'h0);
      want <= 3'h0;
      mot(1'b0, 16'h0);
      rd(TSP_STAT_OFF, 32'h0000_0029, TSP_RESP_OKAY);
      wr(TSP_CTRL_OFF, 32'h1, TSP_RESP_OKAY);
      mot(1'b0, 16'h0);
      wr(TSP_CTRL_OFF, 32'h0, TSP_RESP_OKAY);
      wr(TSP_CTRL_OFF, 32'h1, TSP_RESP_OKAY);
      mot(1'b0, 16'h0);
      wr(TSP_CTRL_OFF, 32'h0, TSP_RESP_OKAY);
      wr(TSP_CTRL_OFF, 32'h3, TSP_RESP_OKAY);
      mot(1'b1, -spd);
      endt();
      want <= 3'h1;
      mot(1'b1, -spd);
      want <= 3'h4;
      mot(1'b0, 16'h0);
      want <= 3'h0;
      mot(1'b1, -spd);
      want <= 3'h2;
      mot(1'b0, 16'h0);
      want <= 3'h0;
      mot(1'b0, 16'h0);
      endt();
      wr(TSP_CTRL_OFF, 32'h0, TSP_RESP_OKAY);
      wr(TSP_CTRL_OFF, 32'h5, TSP_RESP_OKAY);
      want <= 3'h4;
      mot(1'b1, spd);
      want <= 3'h1;
      mot(1'b0, 16'h0);
      want <= 3'h0;
      endt();
      wr(TSP_CTRL_OFF, 32'h0, TSP_RESP_OKAY);
      wr(TSP_CFG_OFF, 32'h0000_110C, TSP_RESP_OKAY);
      wr(TSP_CTRL_OFF, 32'h3, TSP_RESP_OKAY);
      mot(1'b0, 16'h0);
      wr(TSP_CTRL_OFF, 32'h0, TSP_RESP_OKAY);
      wr(TSP_CFG_OFF, TSP_CFG_RST, TSP_RESP_OKAY);
      endt();
      wr(TSP_CFG_OFF, 32'h0000_310B, TSP_RESP_OKAY);
      rd(TSP_CFG_OFF, 32'h0000_310B, TSP_RESP_OKAY);
      wr(TSP_CTRL_OFF, 32'h3, TSP_RESP_OKAY);
      mot(1'b1, -spd);
      want <= 3'h4;
      mot(1'b0, 16'h0);
      want <= 3'h0;
      mot(1'b0, 16'h0);
      endt();
      print_verdict();
   end
endmodule : tb_tsp_positioner
`default_nettype wire
